// ---- rtl/uctl_pkg.sv ----
// Constants for the serial control block: register map, fields, reset values, timing.
// Assumes a 10 MHz pclk and APB with 32-bit data; only the low byte of each register is used, the low nine bits for the data register.
package uctl_pkg;

    // Clock and bit timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_TIME_NS = 1600;
    localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);
    localparam logic [7:0] BIT_HALF = 8'(BIT_CYCLES / 2 - 1);

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h10;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_DATA = 8'h1c;

    // serial_control_one fields
    localparam int C1_LOOPBACK = 7;
    localparam int C1_MODULE_EN = 6;
    localparam int C1_TX_INV = 5;
    localparam int C1_LENGTH = 4;
    localparam int C1_WAKE = 3;
    localparam int C1_IDLE_START = 2;
    localparam int C1_PARITY_EN = 1;
    localparam int C1_PARITY_TYPE = 0;

    // serial_control_two fields
    localparam int C2_TXE_IRQ_EN = 7;
    localparam int C2_TC_IRQ_EN = 6;
    localparam int C2_RXF_IRQ_EN = 5;
    localparam int C2_IDLE_IRQ_EN = 4;
    localparam int C2_TX_EN = 3;
    localparam int C2_RX_EN = 2;
    localparam int C2_STANDBY = 1;
    localparam int C2_BREAK = 0;

    // Status fields (rx_full and idle are write-one-to-clear)
    localparam int ST_TXE = 7;
    localparam int ST_TC = 6;
    localparam int ST_RXF = 5;
    localparam int ST_IDLE = 4;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic TXE_RESET = 1'b1;
    localparam logic TC_RESET = 1'b1;

    // Character lengths in bit times
    localparam logic [3:0] FRAME_SHORT = 4'ha;
    localparam logic [3:0] FRAME_LONG = 4'hb;

    typedef enum logic [1:0] {TX_IDLE, TX_PREAMBLE, TX_BREAK, TX_DATA} uctl_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} uctl_rx_state_t;

endpackage

// ---- rtl/uctl_top.sv ----
// Serial transceiver control path: APB registers, pin sharing, transmitter, receiver wakeup.
// Assumes APB master on pclk; pins and port direction bits are synchronous to pclk.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module uctl_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pin_zero_direction_bit,
    input wire logic pin_one_direction_bit,
    input wire logic port_pin_zero_data,
    input wire logic port_pin_one_data,
    input wire logic port_pin_one_in,
    output logic port_pin_zero_out,
    output logic port_pin_zero_oe_n,
    output logic port_pin_one_out,
    output logic port_pin_one_oe_n,
    output logic tx_irq,
    output logic rx_irq
);
    import uctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] frame_len(input logic long_sel);
        return long_sel ? FRAME_LONG : FRAME_SHORT;
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        return a == ADDR_CTRL_ONE || a == ADDR_CTRL_TWO || a == ADDR_STATUS || a == ADDR_DATA;
    endfunction

    // Frame is sent LSB first: start, data (parity on top), stop, padding ones
    // parity type select
    function automatic logic [10:0] build_frame(input logic [8:0] data, input logic long_sel,
                                                input logic parity_enable, input logic parity_type);
        logic [8:0] d;
        d = data;
        if (long_sel) begin
            if (parity_enable)
                d[8] = ^data[7:0] ^ parity_type;
            return {1'b1, d, 1'b0};
        end
        if (parity_enable)
            d[7] = ^data[6:0] ^ parity_type;
        return {2'b11, d[7:0], 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [7:0] ctrl_one_reg, ctrl_two_reg;
    logic [8:0] tx_data_reg, rx_data_reg;
    logic tx_empty_reg, tx_complete_reg, rx_full_reg, idle_flag_reg;
    logic wr_done, rd_wait;
    logic loop_sel, mod_en, tx_inv, long_sel, wake_sel, idle_start, parity_enable, parity_type;
    logic tx_en, rx_en, standby, send_brk;

    assign loop_sel = ctrl_one_reg[C1_LOOPBACK];
    assign mod_en = ctrl_one_reg[C1_MODULE_EN];
    assign tx_inv = ctrl_one_reg[C1_TX_INV];
    assign long_sel = ctrl_one_reg[C1_LENGTH];
    assign wake_sel = ctrl_one_reg[C1_WAKE];
    assign idle_start = ctrl_one_reg[C1_IDLE_START];
    assign parity_enable = ctrl_one_reg[C1_PARITY_EN];
    assign parity_type = ctrl_one_reg[C1_PARITY_TYPE];
    assign tx_en = ctrl_two_reg[C2_TX_EN];
    assign rx_en = ctrl_two_reg[C2_RX_EN];
    assign standby = ctrl_two_reg[C2_STANDBY];
    assign send_brk = ctrl_two_reg[C2_BREAK];

    // One wait state: the access completes on the edge after pready rises
    assign rd_wait = psel && penable && !pready;
    assign wr_done = psel && penable && pready && pwrite && reg_mapped(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= rd_wait;
            pslverr <= rd_wait && !reg_mapped(paddr);
            if (rd_wait && !pwrite) begin
                unique case (paddr)
                    ADDR_CTRL_ONE: prdata <= {24'h0, ctrl_one_reg};
                    ADDR_CTRL_TWO: prdata <= {24'h0, ctrl_two_reg};
                    ADDR_STATUS: prdata <= {24'h0, tx_empty_reg, tx_complete_reg, rx_full_reg,
                                            idle_flag_reg, 4'h0};
                    ADDR_DATA: prdata <= {23'h0, rx_data_reg};
                    default: prdata <= 32'h0;
                endcase
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmitter

    uctl_tx_state_t tx_state;
    logic [7:0] tx_cnt_reg;
    logic [3:0] tx_bits_reg;
    logic [10:0] tx_sh_reg;
    logic tx_line_reg, pre_pending_reg;
    logic tx_tick, frame_end, after_break, launch_break, launch_pre, launch_data, rx_wake;

    assign tx_tick = mod_en && tx_cnt_reg == BIT_LAST;
    assign frame_end = tx_tick && tx_bits_reg <= 4'h1;
    assign after_break = tx_state == TX_BREAK && !send_brk;
    assign launch_break = frame_end && !after_break && tx_en && send_brk;
    assign launch_pre = frame_end && !after_break && tx_en && !send_brk && pre_pending_reg;
    assign launch_data = frame_end && !after_break && tx_en && !send_brk && !pre_pending_reg
                         && !tx_empty_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one_reg <= CTRL_RESET;
        end else if (wr_done && paddr == ADDR_CTRL_ONE) begin
            ctrl_one_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_two_reg <= CTRL_RESET;
        end else if (wr_done && paddr == ADDR_CTRL_TWO) begin
            ctrl_two_reg <= pwdata[7:0];
        end else if (rx_wake) begin
            ctrl_two_reg[C2_STANDBY] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_reg <= 8'h0;
        end else if (!mod_en || tx_tick) begin
            tx_cnt_reg <= 8'h0;
        end else begin
            tx_cnt_reg <= tx_cnt_reg + 8'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_pending_reg <= 1'b0;
        end else if (!mod_en) begin
            pre_pending_reg <= 1'b0;
        end else if (wr_done && paddr == ADDR_CTRL_TWO && pwdata[C2_TX_EN] && !tx_en) begin
            pre_pending_reg <= 1'b1;
        end else if (launch_pre || launch_break) begin
            pre_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_reg <= TXE_RESET;
            tx_data_reg <= 9'h0;
        end else begin
            if (wr_done && paddr == ADDR_DATA)
                tx_data_reg <= pwdata[8:0];
            if (!mod_en || launch_data)
                tx_empty_reg <= 1'b1;
            else if (wr_done && paddr == ADDR_DATA)
                tx_empty_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_complete_reg <= TC_RESET;
        end else begin
            tx_complete_reg <= !mod_en || (tx_empty_reg && tx_state == TX_IDLE
                               && !pre_pending_reg && !(tx_en && send_brk));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            tx_line_reg <= 1'b1;
            tx_bits_reg <= 4'h0;
            tx_sh_reg <= 11'h7ff;
        end else if (!mod_en) begin
            tx_state <= TX_IDLE;
            tx_line_reg <= 1'b1;
            tx_bits_reg <= 4'h0;
            tx_sh_reg <= 11'h7ff;
        end else if (tx_tick && !frame_end) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_line_reg <= tx_sh_reg[1];
            tx_bits_reg <= tx_bits_reg - 4'h1;
        end else if (launch_break) begin
            tx_state <= TX_BREAK;
            tx_sh_reg <= 11'h0;
            tx_line_reg <= 1'b0;
            tx_bits_reg <= frame_len(long_sel);
        end else if (launch_pre) begin
            tx_state <= TX_PREAMBLE;
            tx_sh_reg <= 11'h7ff;
            tx_line_reg <= 1'b1;
            tx_bits_reg <= frame_len(long_sel);
        end else if (launch_data) begin
            tx_state <= TX_DATA;
            tx_sh_reg <= build_frame(tx_data_reg, long_sel, parity_enable, parity_type);
            tx_line_reg <= 1'b0;
            tx_bits_reg <= frame_len(long_sel);
        end else if (frame_end) begin
            tx_state <= TX_IDLE;
            tx_line_reg <= 1'b1;
            tx_bits_reg <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pins and interrupt requests

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pin_zero_out <= 1'b0;
            port_pin_zero_oe_n <= 1'b1;
            port_pin_one_out <= 1'b0;
            port_pin_one_oe_n <= 1'b1;
        end else begin
            port_pin_zero_out <= mod_en ? tx_line_reg ^ tx_inv : port_pin_zero_data;
            port_pin_zero_oe_n <= mod_en ? 1'b0 : !pin_zero_direction_bit;
            port_pin_one_out <= port_pin_one_data;
            port_pin_one_oe_n <= mod_en ? 1'b1 : !pin_one_direction_bit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            tx_irq <= mod_en && ((tx_empty_reg && ctrl_two_reg[C2_TXE_IRQ_EN])
                      || (tx_complete_reg && ctrl_two_reg[C2_TC_IRQ_EN]));
            rx_irq <= mod_en && !standby && ((rx_full_reg && ctrl_two_reg[C2_RXF_IRQ_EN])
                      || (idle_flag_reg && ctrl_two_reg[C2_IDLE_IRQ_EN]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver

    uctl_rx_state_t rx_state;
    logic [7:0] rx_cnt_reg;
    logic [3:0] rx_bits_reg, ones_reg;
    logic [9:0] rx_sh_reg;
    logic [9:0] rx_sh_next;
    logic rx_in, rx_tick, rx_done, count_step, idle_hit, armed_reg, rx_run;

    assign rx_in = loop_sel ? tx_line_reg ^ tx_inv : port_pin_one_in;
    assign rx_run = mod_en && rx_en;
    assign rx_tick = rx_cnt_reg == BIT_LAST;
    assign rx_sh_next = {rx_in, rx_sh_reg[9:1]};
    assign rx_done = rx_state == RX_BITS && rx_tick && rx_bits_reg == 4'h1;
    assign count_step = rx_tick && (rx_state == RX_IDLE || (rx_state == RX_BITS && !idle_start));
    assign idle_hit = rx_run && count_step && rx_in && ones_reg == frame_len(long_sel) - 4'h1;
    assign rx_wake = standby && ((wake_sel && rx_done && rx_sh_next[8])
                     || (!wake_sel && idle_hit));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_IDLE;
            rx_cnt_reg <= 8'h0;
            rx_bits_reg <= 4'h0;
            rx_sh_reg <= 10'h0;
        end else if (!rx_run) begin
            rx_state <= RX_IDLE;
            rx_cnt_reg <= 8'h0;
            rx_bits_reg <= 4'h0;
        end else begin
            rx_cnt_reg <= rx_tick ? 8'h0 : rx_cnt_reg + 8'h1;
            unique case (rx_state)
                RX_IDLE: begin
                    if (!rx_in) begin
                        rx_state <= RX_START;
                        rx_cnt_reg <= 8'h0;
                    end
                end
                RX_START: begin
                    if (rx_cnt_reg == BIT_HALF) begin
                        rx_state <= rx_in ? RX_IDLE : RX_BITS;
                        rx_cnt_reg <= 8'h0;
                        rx_bits_reg <= frame_len(long_sel) - 4'h1;
                    end
                end
                RX_BITS: begin
                    if (rx_tick) begin
                        rx_sh_reg <= rx_sh_next;
                        rx_bits_reg <= rx_bits_reg - 4'h1;
                        if (rx_bits_reg == 4'h1)
                            rx_state <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ones_reg <= 4'h0;
        end else if (!rx_run || (rx_state == RX_IDLE && !rx_in)) begin
            ones_reg <= 4'h0;
        end else if (count_step) begin
            if (!rx_in)
                ones_reg <= 4'h0;
            else if (ones_reg != frame_len(long_sel))
                ones_reg <= ones_reg + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_reg <= 1'b0;
            idle_flag_reg <= 1'b0;
            armed_reg <= 1'b0;
            rx_data_reg <= 9'h0;
        end else begin
            if (rx_done && (!standby || rx_wake)) begin
                rx_data_reg <= long_sel ? rx_sh_next[8:0] : {1'b0, rx_sh_next[8:1]};
                rx_full_reg <= 1'b1;
                armed_reg <= 1'b1;
            end else if (wr_done && paddr == ADDR_STATUS && pwdata[ST_RXF]) begin
                rx_full_reg <= 1'b0;
            end
            if (idle_hit && armed_reg && !standby) begin
                idle_flag_reg <= 1'b1;
                armed_reg <= 1'b0;
            end else if (wr_done && paddr == ADDR_STATUS && pwdata[ST_IDLE]) begin
                idle_flag_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tx_pin_out: assert property (mod_en |=> !port_pin_zero_oe_n)
        else $error("transmit pin not driven while enabled");
    a_rx_pin_in: assert property (mod_en |=> port_pin_one_oe_n)
        else $error("receive pin driven while enabled");
    a_disable_flags: assert property (!mod_en |=> tx_empty_reg && tx_complete_reg ##1 !tx_irq)
        else $error("disable did not set transmit flags or mask request");
    a_inverted_idle: assert property (mod_en && tx_state == TX_IDLE
        |=> port_pin_zero_out == !$past(tx_inv))
        else $error("idle level not following inversion");
    a_break_zero: assert property (tx_state == TX_BREAK |-> !tx_line_reg)
        else $error("break character carries a one");
    a_frame_len: assert property ((launch_data || launch_break)
        |=> tx_bits_reg == (long_sel ? FRAME_LONG : FRAME_SHORT))
        else $error("frame length wrong");
    a_preamble_queued: assert property (mod_en && $rose(tx_en) && !send_brk
        |-> ##[1:200] tx_state == TX_PREAMBLE)
        else $error("no preamble after transmitter enable");
    a_break_gap: assert property (tx_state == TX_BREAK && frame_end && !send_brk
        |=> tx_state == TX_IDLE && tx_line_reg)
        else $error("no one after break");
    a_standby_mask: assert property (standby && mod_en |=> !rx_irq)
        else $error("receive request while in standby");
    a_tx_irq_gate: assert property (tx_irq |-> $past(tx_empty_reg && ctrl_two_reg[C2_TXE_IRQ_EN])
        || $past(tx_complete_reg && ctrl_two_reg[C2_TC_IRQ_EN]))
        else $error("transmit request without enabled flag");

endmodule // uctl_top

// ---- test/uctl_remote_node.sv ----
// Remote serial node on the shared line: captures frames, sends characters.
// Assumes 16 pclk per bit, 8-bit characters, line idle high.
`timescale 1ns/1ps
module uctl_remote_node (
    input wire logic pclk,
    input wire logic listen,
    input wire logic line_from_dut,
    output logic line_to_dut
);
    logic [9:0] frame_bits;
    int frame_count;
    initial begin
        line_to_dut = 1'b1;
        frame_bits = '0;
        frame_count = 0;
    end
    ////////////////////////////////////////////////////////////////
    // frame capture mid-bit
    always begin
        @(negedge line_from_dut iff listen);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            frame_bits[i] = line_from_dut;
            if (i < 9) repeat (16) @(posedge pclk);
        end
        frame_count++;
    end
    task automatic send_char(input logic [7:0] v);
        logic [9:0] bits;
        bits = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_to_dut <= bits[i];
            repeat (16) @(posedge pclk);
        end
    endtask
endmodule // uctl_remote_node

// ---- test/uctl_top_tb.sv ----
// Self-checking bench for uctl_top: APB register tasks plus a remote node.
// Assumes the node model is compiled first and pclk at 10 MHz.
`timescale 1ns/1ps
module uctl_top_tb;
    import uctl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, listen;
    logic dir_zero, dir_one, rxd, pin0, pin1, oe0, oe1, tx_irq, rx_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    int miscompares, check_count, n, fc;
    localparam logic [31:0] ME = 32'h1 << C1_MODULE_EN;
    localparam logic [31:0] TE = 32'h1 << C2_TX_EN;
    localparam logic [31:0] RE = 32'h1 << C2_RX_EN;

    uctl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_zero_direction_bit(dir_zero),
        .pin_one_direction_bit(dir_one), .port_pin_zero_data(1'b0),
        .port_pin_one_data(1'b1), .port_pin_one_in(rxd), .port_pin_zero_out(pin0),
        .port_pin_zero_oe_n(oe0), .port_pin_one_out(pin1), .port_pin_one_oe_n(oe1),
        .tx_irq(tx_irq), .rx_irq(rx_irq));
    uctl_remote_node node (.pclk(pclk), .listen(listen), .line_from_dut(pin0),
        .line_to_dut(rxd));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Entered right after a rising edge; one idle edge after the access keeps
    // a following call from reassigning psel in the same time step
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1; pwrite <= wr_en; paddr <= a; pwdata <= wd; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic wait_frame();
        for (n = 0; n < 600 && node.frame_count == fc; n++) @(posedge pclk);
    endtask
    task automatic wait_rxf();
        for (n = 0; n < 120 && rd[ST_RXF] !== 1'b1; n++) apb(1'b0, ADDR_STATUS, 0);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(60000 * 100);
        miscompares++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, listen} = '0;
        presetn = 1'b0; dir_zero = 1'b0; dir_one = 1'b1;
        miscompares = 0; check_count = 0; rd = '0; fc = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CTRL_ONE, 0); check("ctrl one reset", 0, rd);
        apb(1'b0, ADDR_CTRL_TWO, 0); check("ctrl two reset", 0, rd);
        apb(1'b0, 8'h00, 0); check("unmapped error", 1, {31'h0, err});
        check("oe idle", 32'h1, {oe1, oe0});
        check("port data out", 32'h2, {pin1, pin0});
        $display("test reset done");
        wr(ADDR_CTRL_ONE, ME);
        repeat (2) @(posedge pclk);
        check("pins shared", 32'h2, {oe1, oe0});
        wr(ADDR_CTRL_TWO, 32'h1 << C2_TXE_IRQ_EN);
        repeat (2) @(posedge pclk);
        check("tx irq", 1, tx_irq);
        wr(ADDR_CTRL_ONE, ME | (32'h1 << C1_TX_INV));
        repeat (3) @(posedge pclk);
        check("inverted idle", 0, pin0);
        wr(ADDR_CTRL_ONE, ME);
        repeat (3) @(posedge pclk);
        listen <= 1'b1;
        $display("test pins done");
        fc = node.frame_count;
        wr(ADDR_DATA, 32'h5a);
        wr(ADDR_CTRL_TWO, TE | RE);
        for (n = 0; n < 400 && pin0 !== 1'b0; n++) @(posedge pclk);
        check("preamble long", 1, n >= 160);
        wait_frame();
        check("frame", 32'h2b4, node.frame_bits);
        for (int p = 0; p < 2; p++) begin
            fc = node.frame_count;
            wr(ADDR_CTRL_ONE, ME | (32'h1 << C1_PARITY_EN) | p);
            wr(ADDR_DATA, 32'h83);
            wait_frame();
            check("parity frame", {22'h0, 1'b1, p[0], 7'h03, 1'b0}, node.frame_bits);
        end
        $display("test transmit done");
        wr(ADDR_CTRL_ONE, ME);
        fc = node.frame_count;
        wr(ADDR_CTRL_TWO, TE | 32'h1);
        wait_frame();
        wr(ADDR_CTRL_TWO, TE);
        check("break frame", 0, node.frame_bits);
        repeat (200) @(posedge pclk);
        check("after break", 1, pin0);
        $display("test break done");
        wr(ADDR_CTRL_TWO, TE | RE | (32'h1 << C2_RXF_IRQ_EN));
        node.send_char(8'ha5);
        wait_rxf();
        apb(1'b0, ADDR_DATA, 0); check("rx data", 32'ha5, {24'h0, rd[7:0]});
        check("rx irq", 1, rx_irq);
        wr(ADDR_CTRL_TWO, TE | RE | (32'h1 << C2_RXF_IRQ_EN) | (32'h1 << C2_STANDBY));
        repeat (2) @(posedge pclk);
        check("standby mask", 0, rx_irq);
        wr(ADDR_CTRL_TWO, TE);
        apb(1'b0, ADDR_STATUS, 0); check("flag kept", 1, rd[ST_RXF]);
        wr(ADDR_STATUS, 32'h1 << ST_RXF);
        wr(ADDR_CTRL_ONE, ME | (32'h1 << C1_WAKE));
        wr(ADDR_CTRL_TWO, TE | RE | (32'h1 << C2_STANDBY));
        node.send_char(8'h81);
        wait_rxf(); check("mark wake full", 1, rd[ST_RXF]);
        apb(1'b0, ADDR_CTRL_TWO, 0); check("mark wake clear", TE | RE, rd);
        apb(1'b0, ADDR_DATA, 0); check("mark data", 32'h81, {24'h0, rd[7:0]});
        wr(ADDR_STATUS, 32'h1 << ST_RXF);
        $display("test receive done");
        wr(ADDR_CTRL_TWO, TE | RE);
        wr(ADDR_CTRL_ONE, ME | (32'h1 << C1_LOOPBACK));
        wr(ADDR_DATA, 32'h3c);
        rd = '0;
        wait_rxf();
        apb(1'b0, ADDR_DATA, 0); check("loop data", 32'h3c, {24'h0, rd[7:0]});
        repeat (200) @(posedge pclk);
        $display("test loopback done");
        wr(ADDR_CTRL_TWO, 32'h1 << C2_TXE_IRQ_EN);
        wr(ADDR_CTRL_ONE, 0);
        repeat (2) @(posedge pclk);
        check("tx irq off", 0, tx_irq);
        apb(1'b0, ADDR_STATUS, 0); check("empty complete", 3, rd[7:6]);
        $display("test disable done");
        finish_test();
    end
endmodule // uctl_top_tb
